// ==== design/esrc_pkg.sv ====
// Purpose: Shared constants and types for the shadow register bank and
//          its bus master.
// Assumes: 25 MHz clock; 8-bit register link.
// Notes:   Factory image is what the store holds until it is programmed.
package esrc_pkg;
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned T_PROG_NS     = 5000000;
    localparam int unsigned PROG_CYCLES   =
        (T_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          CNT_W         = 17;
    typedef logic [CNT_W-1:0] esrc_cnt_t;

    // Register map of the device
    localparam logic [7:0] A_SCRATCH_HI = 8'h1f;
    localparam logic [7:0] A_STRING_REF = 8'h20;
    localparam logic [7:0] A_BOOST_REF  = 8'h21;
    localparam logic [7:0] A_EFF_CTRL   = 8'h40;
    localparam logic [7:0] A_NV_PTR     = 8'h60;
    localparam logic [7:0] A_NV_CTRL    = 8'h61;

    localparam logic [6:0] NV_LAST    = 7'h51;
    localparam int         NV_DEPTH   = int'(NV_LAST) + 1;
    localparam int         PAGE_SHIFT = 3;
    typedef logic [NV_DEPTH-1:0][7:0] esrc_image_t;

    localparam logic [7:0] DEF_STRING_REF = 8'h64;
    localparam logic [7:0] DEF_BOOST_REF  = 8'h64;
    localparam logic [7:0] DEF_EFF_CTRL   = 8'he5;
    localparam logic [7:0] DEF_ZERO       = 8'h00;

    // transfer_command_field codes
    localparam logic [2:0] CMD_OFF  = 3'h0;
    localparam logic [2:0] CMD_RD1  = 3'h1;
    localparam logic [2:0] CMD_RD8  = 3'h2;
    localparam logic [2:0] CMD_WR1  = 3'h3;
    localparam logic [2:0] CMD_WR8  = 3'h4;
    localparam logic [2:0] CMD_UNIV = 3'h5;

    // Host command port
    localparam logic [2:0] H_TGT_ADDR = 3'h0;
    localparam logic [2:0] H_TGT_DATA = 3'h1;
    localparam logic [2:0] H_OP       = 3'h2;
    localparam logic [2:0] H_STATUS   = 3'h3;
    localparam logic [2:0] H_RESULT   = 3'h4;
    localparam logic [2:0] H_ENABLE   = 3'h5;
    localparam logic [1:0] OP_WRITE   = 2'h1;
    localparam logic [1:0] OP_READ    = 2'h2;
    localparam logic [1:0] OP_NV      = 2'h3;

    function automatic esrc_image_t esrc_factory();
        esrc_image_t img;
        img = '0;
        img[A_STRING_REF[6:0]] = DEF_STRING_REF;
        img[A_BOOST_REF[6:0]]  = DEF_BOOST_REF;
        img[A_EFF_CTRL[6:0]]   = DEF_EFF_CTRL;
        return img;
    endfunction

    localparam esrc_image_t NV_FACTORY = esrc_factory();
endpackage

// ==== design/esrc_if.sv ====
// Purpose: Register link between the bank and its bus master.
// Assumes: Single clock; read data one cycle after the read strobe.
// Notes:   en is the device enable input.
`timescale 1ns/100ps
interface esrc_if;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic       en;
    modport dev  (input addr, input wdata, input wr, input rd, input en,
                  output rdata);
    modport host (output addr, output wdata, output wr, output rd,
                  output en, input rdata);
endinterface

// ==== design/esrc_device.sv ====
// Purpose: Control register bank with a nonvolatile shadow image.
// Assumes: RST_N is power-up; NV_FACTORY_N restores the factory image.
// Notes:   Transfers complete at once, then a programming interval runs.
// Summary of operation
// (RL1) Power-up copies stored image into registers
// (RL2) Register writes never touch the stored image
// (RL3) Host leaves undefined registers and bits alone; this host forwards any target address, undefined ones included
// (RL4) Store mirrors registers; program after register write
// (RL5) Code 3 programs one byte at pointer
// (RL6) Host waits 5 ms, then writes zero
// (RL7) Programmed value reloads at every later power-up
// (RL8) Transfers go both directions by command code
// (RL9) Page transfers move eight aligned bytes
// (RL10) Page bases start at zero, step eight
// (RL11) Code 4 programs whole eight-byte page
// (RL12) Host returns control to zero when done
// (RL13) Command codes decode per table; six, seven unused
// (RL14) Pointer is seven bits, range zero to 0x51
// (RL15) Control resets to zero; upper bits ignored
// (RL16) Enable rising edge reloads the register image
// (RL17) Unused codes and busy-time commands ignored
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/100ps
module esrc_device #(
    parameter int unsigned PROG_CYCLES = esrc_pkg::PROG_CYCLES
) (
    input  wire logic       CLK,
    input  wire logic       RST_N,
    input  wire logic       NV_FACTORY_N,
    esrc_if.dev             LINK,
    output logic [7:0]      STRING_CURRENT_REF,
    output logic [7:0]      BOOST_SENSE_REF,
    output logic [7:0]      EFFICIENCY_OPT_CTRL,
    output logic            NV_BUSY,
    output logic            LOADING
);
    typedef enum logic [1:0] {
        ESRC_LOAD = 2'b00,
        ESRC_IDLE = 2'b01,
        ESRC_BUSY = 2'b11
    } esrc_dstate_t;

    typedef struct packed {
        esrc_dstate_t          state;
        logic [6:0]            idx;
        esrc_pkg::esrc_cnt_t   cnt;
        logic [6:0]            ptr;
        logic [2:0]            ctrl;
        logic [7:0]            rdata;
        logic                  en_prev;
        esrc_pkg::esrc_image_t regs;
    } esrc_dev_t;

    localparam esrc_dev_t RESET_VAL = '{
        state:   ESRC_LOAD,
        idx:     7'h00,
        cnt:     '0,
        ptr:     7'h00,
        ctrl:    esrc_pkg::CMD_OFF,
        rdata:   esrc_pkg::DEF_ZERO,
        en_prev: 1'b0,
        regs:    esrc_pkg::NV_FACTORY
    };

    esrc_dev_t             state_reg;
    esrc_dev_t             state_next;
    esrc_pkg::esrc_image_t nvm_reg;
    esrc_pkg::esrc_image_t nvm_next;
    logic                  in_page;
    logic                  is_ctrl_reg;

    function automatic logic reg_mapped(input logic [7:0] a);
        reg_mapped = (a <= esrc_pkg::A_SCRATCH_HI) ||
                     (a == esrc_pkg::A_STRING_REF) ||
                     (a == esrc_pkg::A_BOOST_REF)  ||
                     (a == esrc_pkg::A_EFF_CTRL);
    endfunction

    always_comb begin
        state_next  = state_reg;
        nvm_next    = nvm_reg;
        in_page     = 1'b0;
        is_ctrl_reg = 1'b0;
        state_next.en_prev = LINK.en;

        case (state_reg.state)
            ESRC_LOAD: begin
                // One location per cycle keeps the copy path narrow
                state_next.regs[state_reg.idx] = nvm_reg[state_reg.idx]; // RL1
                if (state_reg.idx == esrc_pkg::NV_LAST) begin
                    state_next.state = ESRC_IDLE;
                end else begin
                    state_next.idx = state_reg.idx + 7'h01;
                end
            end
            ESRC_BUSY: begin
                if (state_reg.cnt <= esrc_pkg::esrc_cnt_t'(1)) begin
                    state_next.state = ESRC_IDLE;
                    state_next.cnt   = '0;
                end else begin
                    state_next.cnt = state_reg.cnt - esrc_pkg::esrc_cnt_t'(1);
                end
            end
            default: begin
            end
        endcase

        // Register reads: one cycle latency
        if (LINK.rd) begin
            if (reg_mapped(LINK.addr)) begin
                state_next.rdata = state_reg.regs[LINK.addr[6:0]];
            end else if (LINK.addr == esrc_pkg::A_NV_PTR) begin
                state_next.rdata = {1'b0, state_reg.ptr}; // RL14
            end else if (LINK.addr == esrc_pkg::A_NV_CTRL) begin
                state_next.rdata = {5'h00, state_reg.ctrl}; // RL15
            end else begin
                state_next.rdata = esrc_pkg::DEF_ZERO;
            end
        end

        // Writes during the reload are dropped; the image would overwrite them
        if (LINK.wr && state_reg.state != ESRC_LOAD) begin
            if (reg_mapped(LINK.addr)) begin
                // Only the live copy changes
                state_next.regs[LINK.addr[6:0]] = LINK.wdata; // RL2
            end else if (LINK.addr == esrc_pkg::A_NV_PTR) begin
                state_next.ptr = LINK.wdata[6:0]; // RL14
            end else if (LINK.addr == esrc_pkg::A_NV_CTRL) begin
                is_ctrl_reg = 1'b1;
            end
        end

        if (is_ctrl_reg) begin
            if (state_reg.state == ESRC_BUSY) begin
                // A command mid-interval is refused; closing is accepted
                if (LINK.wdata[2:0] == esrc_pkg::CMD_OFF) begin // RL17
                    state_next.ctrl = esrc_pkg::CMD_OFF;
                end
            end else begin
                state_next.ctrl = LINK.wdata[2:0]; // RL15
                case (LINK.wdata[2:0]) // RL13
                    esrc_pkg::CMD_RD1: begin
                        if (state_reg.ptr <= esrc_pkg::NV_LAST) begin // RL8
                            state_next.regs[state_reg.ptr] =
                                nvm_reg[state_reg.ptr];
                        end
                        state_next.state = ESRC_BUSY;
                    end
                    esrc_pkg::CMD_RD8: begin
                        for (int i = 0; i < esrc_pkg::NV_DEPTH; i++) begin
                            in_page = ((7'(i) >> esrc_pkg::PAGE_SHIFT) ==
                                (state_reg.ptr >> esrc_pkg::PAGE_SHIFT)); // RL9
                            if (in_page) begin
                                state_next.regs[i] = nvm_reg[i]; // RL8
                            end
                        end
                        state_next.state = ESRC_BUSY;
                    end
                    esrc_pkg::CMD_WR1: begin
                        if (state_reg.ptr <= esrc_pkg::NV_LAST) begin
                            nvm_next[state_reg.ptr] =
                                state_reg.regs[state_reg.ptr]; // RL5
                        end
                        state_next.state = ESRC_BUSY;
                    end
                    esrc_pkg::CMD_WR8: begin
                        for (int i = 0; i < esrc_pkg::NV_DEPTH; i++) begin
                            // Page base is pointer with low three bits cleared
                            in_page = ((7'(i) >> esrc_pkg::PAGE_SHIFT) ==
                                (state_reg.ptr >> esrc_pkg::PAGE_SHIFT)); // RL10
                            if (in_page) begin
                                nvm_next[i] = state_reg.regs[i]; // RL11
                            end
                        end
                        state_next.state = ESRC_BUSY;
                    end
                    esrc_pkg::CMD_UNIV: begin
                        // Whole image to the store
                        nvm_next = state_reg.regs; // RL4
                        state_next.state = ESRC_BUSY;
                    end
                    default: begin
                        // Off and the unused codes start nothing
                        state_next.state = state_reg.state; // RL17
                    end
                endcase
                if (state_next.state == ESRC_BUSY) begin
                    state_next.cnt = esrc_pkg::esrc_cnt_t'(PROG_CYCLES);
                end
            end
        end

        // Enable low loses nothing yet; the rising edge restores the image
        if (LINK.en && !state_reg.en_prev) begin
            state_next.state = ESRC_LOAD; // RL16
            state_next.idx   = 7'h00;
            state_next.cnt   = '0;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_reg <= RESET_VAL;
        end else begin
            state_reg <= state_next;
        end
    end

    // The store survives power-up resets; only the factory restore reloads it, with NV_FACTORY
    always_ff @(posedge CLK or negedge NV_FACTORY_N) begin
        if (!NV_FACTORY_N) begin
            nvm_reg <= esrc_pkg::NV_FACTORY;
        end else begin
            nvm_reg <= nvm_next; // RL7
        end
    end

    assign LINK.rdata          = state_reg.rdata;
    assign STRING_CURRENT_REF  = state_reg.regs[esrc_pkg::A_STRING_REF[6:0]];
    assign BOOST_SENSE_REF     = state_reg.regs[esrc_pkg::A_BOOST_REF[6:0]];
    assign EFFICIENCY_OPT_CTRL = state_reg.regs[esrc_pkg::A_EFF_CTRL[6:0]];
    assign NV_BUSY             = (state_reg.state == ESRC_BUSY);
    assign LOADING             = (state_reg.state == ESRC_LOAD);
endmodule // esrc_device

// ==== design/esrc_host.sv ====
// Purpose: Bus master that runs register accesses and program sequences.
// Assumes: Software port with one-cycle read latency.
// Notes:   A program sequence always ends by writing zero to the control.
`timescale 1ns/100ps
module esrc_host #(
    parameter int unsigned PROG_CYCLES = esrc_pkg::PROG_CYCLES
) (
    input  wire logic       CLK,
    input  wire logic       RST_N,
    input  wire logic [2:0] SW_ADDR,
    input  wire logic [7:0] SW_WDATA,
    input  wire logic       SW_WR,
    input  wire logic       SW_RD,
    output logic [7:0]      SW_RDATA,
    esrc_if.host            LINK
);
    typedef enum logic [2:0] {
        ESRC_H_IDLE  = 3'b000,
        ESRC_H_WR    = 3'b001,
        ESRC_H_RD    = 3'b011,
        ESRC_H_RDCAP = 3'b010,
        ESRC_H_PTR   = 3'b110,
        ESRC_H_CMD   = 3'b111,
        ESRC_H_WAIT  = 3'b101,
        ESRC_H_CLOSE = 3'b100
    } esrc_hstate_t;

    typedef struct packed {
        esrc_hstate_t        state;
        logic [7:0]          tgt_addr;
        logic [7:0]          tgt_data;
        logic [7:0]          result;
        logic                en;
        logic [7:0]          bus_addr;
        logic [7:0]          bus_wdata;
        logic                bus_wr;
        logic                bus_rd;
        logic [7:0]          sw_rdata;
        esrc_pkg::esrc_cnt_t cnt;
    } esrc_host_t;

    esrc_host_t state_reg;
    esrc_host_t state_next;
    logic       busy;

    assign busy = (state_reg.state != ESRC_H_IDLE);

    always_comb begin
        state_next        = state_reg;
        state_next.bus_wr = 1'b0;
        state_next.bus_rd = 1'b0;

        if (SW_RD) begin
            if (SW_ADDR == esrc_pkg::H_TGT_ADDR) begin
                state_next.sw_rdata = state_reg.tgt_addr;
            end else if (SW_ADDR == esrc_pkg::H_TGT_DATA) begin
                state_next.sw_rdata = state_reg.tgt_data;
            end else if (SW_ADDR == esrc_pkg::H_STATUS) begin
                state_next.sw_rdata = {6'h00, state_reg.en, busy};
            end else if (SW_ADDR == esrc_pkg::H_RESULT) begin
                state_next.sw_rdata = state_reg.result;
            end else if (SW_ADDR == esrc_pkg::H_ENABLE) begin
                state_next.sw_rdata = {7'h00, state_reg.en};
            end else begin
                state_next.sw_rdata = esrc_pkg::DEF_ZERO;
            end
        end

        if (SW_WR) begin
            if (SW_ADDR == esrc_pkg::H_TGT_ADDR) begin
                state_next.tgt_addr = SW_WDATA;
            end else if (SW_ADDR == esrc_pkg::H_TGT_DATA) begin
                state_next.tgt_data = SW_WDATA;
            end else if (SW_ADDR == esrc_pkg::H_ENABLE) begin
                state_next.en = SW_WDATA[0];
            end else if (SW_ADDR == esrc_pkg::H_OP && !busy) begin
                // A write op puts only the addressed register on the link, defined or not
                state_next.bus_addr  = state_reg.tgt_addr; // RL3
                state_next.bus_wdata = state_reg.tgt_data;
                if (SW_WDATA[1:0] == esrc_pkg::OP_WRITE) begin
                    state_next.bus_wr = 1'b1;
                    state_next.state  = ESRC_H_WR;
                end else if (SW_WDATA[1:0] == esrc_pkg::OP_READ) begin
                    state_next.bus_rd = 1'b1;
                    state_next.state  = ESRC_H_RD;
                end else if (SW_WDATA[1:0] == esrc_pkg::OP_NV) begin
                    // Pointer first, then the command code
                    state_next.bus_addr  = esrc_pkg::A_NV_PTR; // RL9
                    state_next.bus_wdata = state_reg.tgt_addr;
                    state_next.bus_wr    = 1'b1;
                    state_next.state     = ESRC_H_PTR;
                end
            end
        end

        case (state_reg.state)
            ESRC_H_WR: begin
                state_next.state = ESRC_H_IDLE;
            end
            ESRC_H_RD: begin
                state_next.state = ESRC_H_RDCAP;
            end
            ESRC_H_RDCAP: begin
                state_next.result = LINK.rdata;
                state_next.state  = ESRC_H_IDLE;
            end
            ESRC_H_PTR: begin
                state_next.bus_addr  = esrc_pkg::A_NV_CTRL;
                state_next.bus_wdata = {5'h00, state_reg.tgt_data[2:0]};
                state_next.bus_wr    = 1'b1; // RL5
                state_next.state     = ESRC_H_CMD;
            end
            ESRC_H_CMD: begin
                state_next.cnt   = esrc_pkg::esrc_cnt_t'(PROG_CYCLES);
                state_next.state = ESRC_H_WAIT;
            end
            ESRC_H_WAIT: begin
                // One extra cycle of margin over the device's own interval
                if (state_reg.cnt == '0) begin
                    state_next.bus_addr  = esrc_pkg::A_NV_CTRL;
                    state_next.bus_wdata = esrc_pkg::DEF_ZERO; // RL12
                    state_next.bus_wr    = 1'b1; // RL6
                    state_next.state     = ESRC_H_CLOSE;
                end else begin
                    state_next.cnt = state_reg.cnt - esrc_pkg::esrc_cnt_t'(1);
                end
            end
            ESRC_H_CLOSE: begin
                state_next.state = ESRC_H_IDLE;
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign SW_RDATA   = state_reg.sw_rdata;
    assign LINK.addr  = state_reg.bus_addr;
    assign LINK.wdata = state_reg.bus_wdata;
    assign LINK.wr    = state_reg.bus_wr;
    assign LINK.rd    = state_reg.bus_rd;
    assign LINK.en    = state_reg.en;
endmodule // esrc_host

// ==== tb/esrc_asserts.sv ====
// Purpose: Timing and read-value checks on the register link between host and bank.
// Assumes: One clock; RST_N asynchronous, active low.
// Notes:   Watches the link only; bank outputs are judged by the bench.
`timescale 1ns/100ps
module esrc_asserts #(
    parameter int unsigned PROG_CYCLES = esrc_pkg::PROG_CYCLES
) (
    input wire logic       CLK,
    input wire logic       RST_N,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic       en
);
    typedef struct packed {
        esrc_pkg::esrc_cnt_t since_cmd;
    } esrc_chk_t;

    localparam int W_LO = int'(PROG_CYCLES);
    localparam int W_HI = int'(PROG_CYCLES) + 6;

    esrc_chk_t st_reg;
    esrc_chk_t st_next;
    logic      ctrl_wr;
    logic      nv_cmd;
    logic      unmapped;

    assign ctrl_wr  = wr && addr == esrc_pkg::A_NV_CTRL;
    assign nv_cmd   = ctrl_wr && wdata[2:0] != 3'h0;
    assign unmapped = addr > esrc_pkg::A_BOOST_REF
                      && addr != esrc_pkg::A_EFF_CTRL
                      && addr != esrc_pkg::A_NV_PTR
                      && addr != esrc_pkg::A_NV_CTRL;

    // Saturating count keeps the width small for long programming times
    always_comb begin
        st_next = st_reg;
        if (nv_cmd) begin
            st_next.since_cmd = '0;
        end else if (int'(st_reg.since_cmd) < int'(PROG_CYCLES)) begin
            st_next.since_cmd = st_reg.since_cmd + 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            st_reg.since_cmd <= esrc_pkg::esrc_cnt_t'(PROG_CYCLES);
        end else begin
            st_reg <= st_next;
        end
    end

    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);

    one_strobe_a: assert property (!(wr && rd))
        else $error("link strobes raised together");
    prog_wait_a: assert property (ctrl_wr |->
        int'(st_reg.since_cmd) + 1 >= int'(PROG_CYCLES))
        else $error("control written inside programming time");
    close_cycle_a: assert property (nv_cmd |->
        ##[W_LO:W_HI] (ctrl_wr && wdata[2:0] == 3'h0))
        else $error("transfer cycle not closed in time");
    pointer_first_a: assert property (nv_cmd |->
        $past(wr && addr == esrc_pkg::A_NV_PTR))
        else $error("command not preceded by pointer load");
    read_hold_a: assert property (!rd |=> $stable(rdata))
        else $error("read data moved without a read");
    unmapped_zero_a: assert property (rd && unmapped |=>
        rdata == 8'h00)
        else $error("unmapped read not zero");
    pointer_width_a: assert property (rd && addr == esrc_pkg::A_NV_PTR
        |=> !rdata[7])
        else $error("pointer top bit read back set");
    ctrl_width_a: assert property (rd && addr == esrc_pkg::A_NV_CTRL
        |=> rdata[7:3] == 5'h00)
        else $error("control upper bits read back set");

    cover property (nv_cmd);
    cover property (rd && unmapped);
    cover property ($rose(en));
endmodule // esrc_asserts

// ==== tb/eeprom_shadow_register_control_test.sv ====
// Purpose: Drives the host software port and judges the shadow bank.
// Assumes: Short programming time; one clock at 25 MHz.
// Notes:   Power cycles are RST_N pulses; the store survives them.
`timescale 1ns/100ps
module eeprom_shadow_register_control_test;
    localparam int unsigned PROG = 8;
    logic       clk     = 1'b0;
    logic       rst_n   = 1'b0;
    logic       fact_n  = 1'b0;
    logic [2:0] sw_addr = 3'h0;
    logic [7:0] sw_data = 8'h00;
    logic       sw_wr   = 1'b0;
    logic       sw_rd   = 1'b0;
    logic [7:0] sw_rdata;
    logic [7:0] str_ref;
    logic [7:0] bst_ref;
    logic [7:0] eff_ctrl;
    logic       nv_busy;
    logic       loading;
    logic [7:0] d;
    int         err_count       = 0;
    int         samples_checked = 0;

    esrc_if link ();
    esrc_device #(.PROG_CYCLES(PROG)) i_esrc_device (.CLK(clk),
        .RST_N(rst_n), .NV_FACTORY_N(fact_n), .LINK(link),
        .STRING_CURRENT_REF(str_ref), .BOOST_SENSE_REF(bst_ref),
        .EFFICIENCY_OPT_CTRL(eff_ctrl), .NV_BUSY(nv_busy),
        .LOADING(loading));
    esrc_host #(.PROG_CYCLES(PROG)) i_esrc_host (.CLK(clk), .RST_N(rst_n),
        .SW_ADDR(sw_addr), .SW_WDATA(sw_data), .SW_WR(sw_wr),
        .SW_RD(sw_rd), .SW_RDATA(sw_rdata), .LINK(link));
    esrc_asserts #(.PROG_CYCLES(PROG)) i_esrc_asserts (.CLK(clk),
        .RST_N(rst_n), .addr(link.addr), .wdata(link.wdata), .wr(link.wr),
        .rd(link.rd), .rdata(link.rdata), .en(link.en));

    initial begin
        forever #20 clk = ~clk;
    end

    task automatic close_out();
        if (err_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check8(input string what, input logic [7:0] exp,
                          input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic host_wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        sw_addr <= a;
        sw_data <= v;
        sw_wr   <= 1'b1;
        @(posedge clk);
        sw_wr   <= 1'b0;
    endtask

    task automatic host_rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk);
        sw_addr <= a;
        sw_rd   <= 1'b1;
        @(posedge clk);
        sw_rd   <= 1'b0;
        #1 v = sw_rdata;
    endtask

    // Polls status rather than timing, so a slow load still settles
    task automatic settle();
        logic [7:0] s;
        int         n;
        n = 0;
        do begin
            host_rd(esrc_pkg::H_STATUS, s);
            n++;
        end while ((s[0] !== 1'b0 || loading !== 1'b0) && n < 300);
        check8("busy", 8'h00, {7'h00, s[0] | loading});
    endtask

    task automatic link_wr(input logic [7:0] a, input logic [7:0] v);
        host_wr(esrc_pkg::H_TGT_ADDR, a);
        host_wr(esrc_pkg::H_TGT_DATA, v);
        host_wr(esrc_pkg::H_OP, {6'h00, esrc_pkg::OP_WRITE});
        repeat (3) @(posedge clk);
    endtask

    task automatic link_rd(input logic [7:0] a, output logic [7:0] v);
        host_wr(esrc_pkg::H_TGT_ADDR, a);
        host_wr(esrc_pkg::H_OP, {6'h00, esrc_pkg::OP_READ});
        repeat (4) @(posedge clk);
        host_rd(esrc_pkg::H_RESULT, v);
    endtask

    task automatic nv_op(input logic [7:0] ptr, input logic [2:0] code);
        logic go;
        go = code != esrc_pkg::CMD_OFF && code <= esrc_pkg::CMD_UNIV;
        host_wr(esrc_pkg::H_TGT_ADDR, ptr);
        host_wr(esrc_pkg::H_TGT_DATA, {5'h00, code});
        host_wr(esrc_pkg::H_OP, {6'h00, esrc_pkg::OP_NV});
        repeat (2) @(posedge clk);
        // Command landed on the last edge; only real codes start an interval
        @(negedge clk);
        check8("nv busy", {7'h00, go}, {7'h00, nv_busy});
        settle();
    endtask

    task automatic pwr_cycle();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        host_wr(esrc_pkg::H_ENABLE, 8'h01);
        settle();
    endtask

    task automatic t_defaults();
        check8("string ref", esrc_pkg::DEF_STRING_REF, str_ref);
        check8("boost ref", esrc_pkg::DEF_BOOST_REF, bst_ref);
        check8("eff ctrl", esrc_pkg::DEF_EFF_CTRL, eff_ctrl);
        link_rd(esrc_pkg::A_NV_CTRL, d);
        check8("ctrl reset", 8'h00, d);
        link_rd(esrc_pkg::A_NV_PTR, d);
        check8("ptr reset", 8'h00, d);
        link_wr(esrc_pkg::A_NV_PTR, 8'hff);
        link_rd(esrc_pkg::A_NV_PTR, d);
        check8("ptr width", 8'h7f, d);
        link_wr(esrc_pkg::A_NV_CTRL, 8'hf8);
        link_rd(esrc_pkg::A_NV_CTRL, d);
        check8("ctrl width", 8'h00, d);
        link_wr(8'h30, 8'hff);
        link_rd(8'h30, d);
        check8("unmapped", 8'h00, d);
        host_rd(esrc_pkg::H_TGT_ADDR, d);
        check8("target addr", 8'h30, d);
    endtask

    task automatic t_byte_prog();
        link_wr(esrc_pkg::A_STRING_REF, 8'h32);
        check8("string live", 8'h32, str_ref);
        pwr_cycle();
        check8("string lost", 8'h64, str_ref);
        link_wr(esrc_pkg::A_STRING_REF, 8'h32);
        nv_op(esrc_pkg::A_STRING_REF, esrc_pkg::CMD_WR1);
        pwr_cycle();
        check8("string kept", 8'h32, str_ref);
    endtask

    // Neighbours of the page prove the eight-byte boundary
    task automatic t_page();
        for (int i = 0; i < 10; i++) link_wr(8'h07 + 8'(i), 8'ha0 + 8'(i));
        nv_op(8'h08, esrc_pkg::CMD_WR8);
        for (int i = 0; i < 10; i++) link_wr(8'h07 + 8'(i), 8'h55);
        pwr_cycle();
        for (int i = 0; i < 10; i++) begin
            link_rd(8'h07 + 8'(i), d);
            check8("page", (i == 0 || i == 9) ? 8'h00 : 8'ha0 + 8'(i),
                   d);
        end
    endtask

    task automatic t_reads();
        link_wr(esrc_pkg::A_BOOST_REF, 8'h77);
        nv_op(esrc_pkg::A_BOOST_REF, esrc_pkg::CMD_RD1);
        check8("read one", 8'h64, bst_ref);
        link_wr(8'h09, 8'h99);
        nv_op(8'h08, esrc_pkg::CMD_RD8);
        link_rd(8'h09, d);
        check8("read page", 8'ha2, d);
        link_wr(esrc_pkg::A_EFF_CTRL, 8'h3c);
        nv_op(8'h00, esrc_pkg::CMD_UNIV);
        link_wr(esrc_pkg::A_BOOST_REF, 8'h5a);
        nv_op(esrc_pkg::A_BOOST_REF, 3'h6);
        nv_op(esrc_pkg::A_BOOST_REF, 3'h7);
        pwr_cycle();
        check8("universal", 8'h3c, eff_ctrl);
        check8("unused code", 8'h64, bst_ref);
    endtask

    task automatic t_enable();
        link_wr(esrc_pkg::A_STRING_REF, 8'h11);
        link_wr(8'h09, 8'h44);
        host_wr(esrc_pkg::H_ENABLE, 8'h00);
        host_rd(esrc_pkg::H_ENABLE, d);
        check8("enable off", 8'h00, d);
        repeat (3) @(posedge clk);
        host_wr(esrc_pkg::H_ENABLE, 8'h01);
        settle();
        check8("enable reg", 8'h32, str_ref);
        link_rd(8'h09, d);
        check8("enable ram", 8'ha2, d);
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        err_count++;
        close_out();
    end

    initial begin
        repeat (5) @(posedge clk);
        rst_n  <= 1'b1;
        fact_n <= 1'b1;
        host_wr(esrc_pkg::H_ENABLE, 8'h01);
        settle();
        t_defaults();
        t_byte_prog();
        t_page();
        t_reads();
        t_enable();
        close_out();
    end
endmodule // eeprom_shadow_register_control_test
